// ---- verilog/spi_wdt_pkg.sv ----
package spi_wdt_pkg;
  // Clock and link timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int HALF_W = 4;

  // Supervisor timing: count step and window length for selector 00
  localparam int LSB_BASE_NS = 204800;
  localparam int LSB_BASE_CYCLES = LSB_BASE_NS / CLK_PERIOD_NS;
  localparam int WIN_BASE_NS = 11260000;
  localparam int WIN_STEPS_INT = (WIN_BASE_NS + LSB_BASE_NS / 2) / LSB_BASE_NS;
  localparam int PRESC_W = 17;
  localparam int WCNT_W = 6;
  localparam logic [WCNT_W-1:0] WIN_STEPS = WCNT_W'(WIN_STEPS_INT);

  // Link frame layout
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam int FR_WRITE = 15;
  localparam int FR_ADDR_LO = 12;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 12;

  // Device register addresses
  localparam logic [ADDR_W-1:0] ADDR_CFG = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_REFRESH = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_WCOUNT = 3'h3;

  // Configuration register fields
  localparam int CFG_EN = 0;
  localparam int CFG_WIN_LO = 1;
  localparam int CFG_LIM_LO = 3;
  localparam int CFG_CLR_LO = 5;
  localparam logic [1:0] WIN_SEL_RST = 2'h1;
  localparam logic [1:0] LIM_SEL_RST = 2'h3;
  localparam logic [1:0] CLR_CMD_RST = 2'h1;
  localparam logic [1:0] CLR_CMD_RESET = 2'h2;

  // Status register fields
  localparam int ST_ACTIVE = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_SEQERR = 2;
  localparam int ST_ECNT_LO = 3;

  // Host register offsets
  localparam logic [7:0] HOST_TX = 8'h00;
  localparam logic [7:0] HOST_RX = 8'h04;
  localparam logic [7:0] HOST_STATUS = 8'h08;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ---- verilog/spi_wdt_if.sv ----
`timescale 1ns/10ps
interface spi_wdt_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // Undriven line floats high through a pull-up
  assign miso_line = miso_oe ? miso : 1'b1;

  modport host (output sclk, output cs_n, output mosi, input miso_line);
  modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
endinterface

// ---- verilog/spi_target_shift.sv ----
`timescale 1ns/10ps
module spi_target_shift
  import spi_wdt_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Frame side
  input wire logic [FRAME_W-1:0] tx_word,
  output logic [FRAME_W-1:0] rx_word,
  output logic rx_done
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [FRAME_W-1:0] sh_in_q;
  logic [FRAME_W-1:0] sh_out_q;
  logic [CNT_W-1:0] cnt_q;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  // Two-stage synchronisers: {sclk, cs_n, mosi}
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= 3'h2;
      s2_q <= 3'h2;
      s3_q <= 3'h2;
    end
    else
    begin
      s1_q <= {sclk, cs_n, mosi};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q[2] & ~s3_q[2] & ~s2_q[1];
  assign fall = ~s2_q[2] & s3_q[2] & ~s2_q[1];
  assign cs_fall = ~s2_q[1] & s3_q[1];
  assign cs_rise = s2_q[1] & ~s3_q[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sh_in_q <= '0;
      cnt_q <= '0;
    end
    else if (cs_fall)
    begin
      sh_in_q <= '0;
      cnt_q <= '0;
    end
    else if (rise)
    begin
      sh_in_q <= {sh_in_q[FRAME_W-2:0], s2_q[0]};
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sh_out_q <= '0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      miso_oe <= ~s2_q[1];
      if (cs_fall)
      begin
        sh_out_q <= {tx_word[FRAME_W-2:0], 1'b0};
        miso <= tx_word[FRAME_W-1];
      end
      else if (fall)
      begin
        sh_out_q <= {sh_out_q[FRAME_W-2:0], 1'b0};
        miso <= sh_out_q[FRAME_W-1];
      end
    end
  end

  // Frames of the wrong length are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_word <= '0;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= cs_rise && (cnt_q == CNT_W'(FRAME_W));
      if (cs_rise)
        rx_word <= sh_in_q;
    end
  end
endmodule

// ---- verilog/wdt_device.sv ----
`timescale 1ns/10ps
module wdt_device
  import spi_wdt_pkg::*;
#(
  parameter int LSB_CYCLES = LSB_BASE_CYCLES
)
(
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cfg_rst_n,
  // Link
  spi_wdt_if.device link,
  // Device status
  output logic supervisor_active_flag,
  output logic window_timeout_flag,
  output logic sequence_error_flag,
  output logic gate_drv_off,
  output logic charge_pump_off
);
  import spi_wdt_pkg::*;

  logic [FRAME_W-1:0] rx_word;
  logic rx_done;
  logic [FRAME_W-1:0] reply_q;
  logic supervisor_enable_q;
  logic [1:0] window_length_sel_q;
  logic [1:0] error_limit_sel_q;
  logic [1:0] fault_clear_cmd_q;
  logic [PRESC_W-1:0] presc_q;
  logic [WCNT_W-1:0] window_count_status_q;
  logic [3:0] expect_q;
  logic [1:0] error_count_status_q;
  logic wr_cfg;
  logic wr_refresh;
  logic [3:0] cmd;
  logic good_cmd;
  logic bad_cmd;
  logic clear_req;
  logic tick;
  logic win_elapsed;
  logic seq_hit;
  logic faulted;
  logic [DATA_W-1:0] cfg_view;
  logic [DATA_W-1:0] status_view;

  function automatic logic [3:0] to_gray(input logic [3:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  function automatic logic [1:0] limit_of(input logic [1:0] sel);
    limit_of = (sel == 2'h0) ? 2'h1 : sel;
  endfunction

  function automatic logic [PRESC_W-1:0] step_cycles(input logic [1:0] sel);
    step_cycles = PRESC_W'(LSB_CYCLES) << sel;
  endfunction

  spi_target_shift u_shift (
    .hclk(hclk),
    .hresetn(hresetn),
    .sclk(link.sclk),
    .cs_n(link.cs_n),
    .mosi(link.mosi),
    .miso(link.miso),
    .miso_oe(link.miso_oe),
    .tx_word(reply_q),
    .rx_word(rx_word),
    .rx_done(rx_done)
  );

  assign wr_cfg = rx_done && rx_word[FR_WRITE]
    && (rx_word[FR_WRITE-1:FR_ADDR_LO] == ADDR_CFG);
  assign wr_refresh = rx_done && rx_word[FR_WRITE]
    && (rx_word[FR_WRITE-1:FR_ADDR_LO] == ADDR_REFRESH);
  assign cmd = rx_word[3:0];
  assign faulted = window_timeout_flag | sequence_error_flag;
  assign good_cmd = wr_refresh && supervisor_enable_q && (cmd == expect_q);
  assign bad_cmd = wr_refresh && supervisor_enable_q && (cmd != expect_q);
  assign clear_req = wr_cfg && faulted
    && (rx_word[CFG_CLR_LO+1:CFG_CLR_LO] == CLR_CMD_RESET);
  assign tick = supervisor_enable_q && !window_timeout_flag
    && (presc_q == step_cycles(window_length_sel_q) - PRESC_W'(1));
  assign win_elapsed = tick && (window_count_status_q == WIN_STEPS - WCNT_W'(1));
  // Compare one bit wider so a saturated count cannot wrap to zero
  assign seq_hit = bad_cmd
    && ({1'b0, error_count_status_q} + 3'h1
    >= {1'b0, limit_of(error_limit_sel_q)});

  // Enable and configuration
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      supervisor_enable_q <= 1'b0;
      window_length_sel_q <= WIN_SEL_RST;
      error_limit_sel_q <= LIM_SEL_RST;
      fault_clear_cmd_q <= CLR_CMD_RST;
    end
    else if (!cfg_rst_n)
    begin
      supervisor_enable_q <= 1'b0;
      window_length_sel_q <= WIN_SEL_RST;
      error_limit_sel_q <= LIM_SEL_RST;
      fault_clear_cmd_q <= CLR_CMD_RST;
    end
    else if (wr_cfg)
    begin
      if (rx_word[CFG_EN])
        supervisor_enable_q <= 1'b1;
      if (!supervisor_enable_q)
        window_length_sel_q <= rx_word[CFG_WIN_LO+1:CFG_WIN_LO];
      error_limit_sel_q <= rx_word[CFG_LIM_LO+1:CFG_LIM_LO];
      fault_clear_cmd_q <= rx_word[CFG_CLR_LO+1:CFG_CLR_LO];
    end
  end

  // Overflow prescaler and window counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      presc_q <= '0;
      window_count_status_q <= '0;
    end
    else if (!cfg_rst_n || !supervisor_enable_q || good_cmd || clear_req)
    begin
      presc_q <= '0;
      window_count_status_q <= '0;
    end
    else if (!window_timeout_flag)
    begin
      if (tick)
      begin
        presc_q <= '0;
        window_count_status_q <= win_elapsed ? '0 : window_count_status_q + WCNT_W'(1);
      end
      else
        presc_q <= presc_q + PRESC_W'(1);
    end
  end

  // Expected command and error counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      expect_q <= '0;
      error_count_status_q <= '0;
    end
    else if (!cfg_rst_n || !supervisor_enable_q)
    begin
      expect_q <= '0;
      error_count_status_q <= '0;
    end
    else if (clear_req)
      error_count_status_q <= '0;
    else if (good_cmd)
    begin
      expect_q <= expect_q + 4'h1;
      if (error_count_status_q != 2'h0)
        error_count_status_q <= error_count_status_q - 2'h1;
    end
    else if (bad_cmd && !seq_hit)
      error_count_status_q <= error_count_status_q + 2'h1;
    else if (seq_hit)
      error_count_status_q <= limit_of(error_limit_sel_q);
  end

  // Sticky fault flags; a new fault wins over a clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      window_timeout_flag <= 1'b0;
      sequence_error_flag <= 1'b0;
    end
    else if (!cfg_rst_n)
    begin
      window_timeout_flag <= 1'b0;
      sequence_error_flag <= 1'b0;
    end
    else
    begin
      if (win_elapsed)
        window_timeout_flag <= 1'b1;
      else if (clear_req)
        window_timeout_flag <= 1'b0;
      if (seq_hit)
        sequence_error_flag <= 1'b1;
      else if (clear_req)
        sequence_error_flag <= 1'b0;
    end
  end

  // Safe state and activity outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gate_drv_off <= 1'b0;
      charge_pump_off <= 1'b0;
      supervisor_active_flag <= 1'b0;
    end
    else
    begin
      gate_drv_off <= faulted;
      charge_pump_off <= faulted;
      supervisor_active_flag <= supervisor_enable_q;
    end
  end

  assign cfg_view = {5'h0, fault_clear_cmd_q, error_limit_sel_q,
    window_length_sel_q, supervisor_enable_q};
  assign status_view = {7'h0, error_count_status_q, sequence_error_flag,
    window_timeout_flag, supervisor_active_flag};

  // Reply carried out in the next frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reply_q <= '0;
    else if (rx_done)
    begin
      reply_q[FRAME_W-1:DATA_W] <= rx_word[FRAME_W-1:DATA_W];
      unique case (rx_word[FR_WRITE-1:FR_ADDR_LO])
        ADDR_CFG: reply_q[DATA_W-1:0] <= cfg_view;
        ADDR_REFRESH: reply_q[DATA_W-1:0] <= {8'h0, to_gray(cmd)};
        ADDR_STATUS: reply_q[DATA_W-1:0] <= status_view;
        ADDR_WCOUNT: reply_q[DATA_W-1:0] <= {6'h0, window_count_status_q};
        default: reply_q[DATA_W-1:0] <= '0;
      endcase
    end
  end
endmodule

// ---- verilog/wdt_host.sv ----
`timescale 1ns/10ps
module wdt_host
  import spi_wdt_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Link
  spi_wdt_if.host link
);
  import spi_wdt_pkg::*;

  typedef enum logic [1:0] {IDLE, LEAD, SHIFT, TRAIL} phase_t;

  phase_t phase_q;
  logic [1:0] miso_s_q;
  logic [HALF_W-1:0] div_q;
  logic [CNT_W-1:0] bits_q;
  logic [FRAME_W-1:0] tx_q;
  logic [FRAME_W-1:0] rx_q;
  logic [FRAME_W-1:0] shift_q;
  logic done_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic half_end;
  logic start;
  logic rx_read;

  assign half_end = (div_q == HALF_W'(SCLK_HALF_CYCLES - 1));
  assign start = wr_pend_q && (wr_addr_q == HOST_TX) && (phase_q == IDLE);
  // A read of the receive register clears the done flag
  assign rx_read = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite
    && (haddr[7:0] == HOST_RX);

  // AHB-Lite: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= '0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
      if (hsel && hready && (htrans == HTRANS_NONSEQ))
        wr_addr_q <= haddr[7:0];
      if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite)
      begin
        unique case (haddr[7:0])
          HOST_TX: hrdata <= {16'h0, tx_q};
          HOST_RX: hrdata <= {16'h0, rx_q};
          HOST_STATUS: hrdata <= {30'h0, done_q, phase_q != IDLE};
          default: hrdata <= '0;
        endcase
      end
    end
  end

  // Two-stage synchroniser for the returned data line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      miso_s_q <= 2'h3;
    else
      miso_s_q <= {miso_s_q[0], link.miso_line};
  end

  // Frame engine, SCLK made by dividing hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_q <= IDLE;
      div_q <= '0;
      bits_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      shift_q <= '0;
      done_q <= 1'b0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
    end
    else
    begin
      if (start)
        done_q <= 1'b0;
      else if (rx_read)
        done_q <= 1'b0;
      div_q <= (phase_q == IDLE || half_end) ? '0 : div_q + HALF_W'(1);
      unique case (phase_q)
        IDLE:
          if (start)
          begin
            tx_q <= hwdata[FRAME_W-1:0];
            shift_q <= {hwdata[FRAME_W-2:0], 1'b0};
            link.mosi <= hwdata[FRAME_W-1];
            link.cs_n <= 1'b0;
            bits_q <= '0;
            phase_q <= LEAD;
          end
        LEAD:
          if (half_end)
          begin
            link.sclk <= 1'b1;
            phase_q <= SHIFT;
          end
        SHIFT:
          if (half_end)
          begin
            if (link.sclk)
            begin
              link.sclk <= 1'b0;
              rx_q <= {rx_q[FRAME_W-2:0], miso_s_q[1]};
              bits_q <= bits_q + CNT_W'(1);
              link.mosi <= shift_q[FRAME_W-1];
              shift_q <= {shift_q[FRAME_W-2:0], 1'b0};
              if (bits_q == CNT_W'(FRAME_W - 1))
                phase_q <= TRAIL;
            end
            else
              link.sclk <= 1'b1;
          end
        TRAIL:
          if (half_end)
          begin
            link.cs_n <= 1'b1;
            done_q <= 1'b1;
            phase_q <= IDLE;
          end
      endcase
    end
  end
endmodule

// ---- dv/spi_wdt_sva.sv ----
`timescale 1ns/10ps
module spi_wdt_sva (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cfg_rst_n,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line,
  // Device status
  input wire logic supervisor_active_flag,
  input wire logic window_timeout_flag,
  input wire logic sequence_error_flag,
  input wire logic gate_drv_off,
  input wire logic charge_pump_off
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic sclk_q;
  logic [4:0] rises_q;

  // Clock rises seen within the current frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_q <= 1'b0;
      rises_q <= 5'h0;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_n)
        rises_q <= 5'h0;
      else if (sclk && !sclk_q)
        rises_q <= rises_q + 5'h1;
    end
  end

  frame_len_a: assert property ($rose(cs_n) |-> rises_q == 5'h10)
    else $error("frame without sixteen clock rises");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock moves outside a frame");
  miso_on_a: assert property ($fell(cs_n) |-> ##[2:5] miso_oe)
    else $error("reply line not driven in frame");
  miso_off_a: assert property (cs_n [*4] |-> !miso_oe && miso_line)
    else $error("reply line driven between frames");
  miso_hold_a: assert property (sclk && $past(sclk) |-> $stable(miso) && $stable(miso_line))
    else $error("reply line moved while link clock high");
  active_hold_a: assert property ($fell(supervisor_active_flag) |->
    !$past(cfg_rst_n) || !$past(cfg_rst_n, 2))
    else $error("active flag fell without reset");
  active_set_a: assert property ($rose(supervisor_active_flag) |-> cs_n && $past(cs_n))
    else $error("active flag rose inside a frame");
  cfg_clear_a: assert property (!cfg_rst_n |-> ##2 !supervisor_active_flag)
    else $error("config reset left supervisor on");
  fault_sticky_a: assert property ($fell(window_timeout_flag) |->
    !$past(cfg_rst_n) || (cs_n && $past(cs_n, 2)))
    else $error("timeout flag cleared without command");
  timeout_cause_a: assert property ($rose(window_timeout_flag) |-> supervisor_active_flag)
    else $error("timeout flag while disabled");
  seq_cause_a: assert property ($rose(sequence_error_flag) |->
    cs_n && supervisor_active_flag)
    else $error("sequence flag without a command");
  safe_state_a: assert property (gate_drv_off ==
    $past(window_timeout_flag || sequence_error_flag))
    else $error("gate drivers not following faults");
  pump_off_a: assert property (charge_pump_off == gate_drv_off)
    else $error("charge pump differs from gate drivers");

  cover property ($rose(window_timeout_flag));
  cover property ($rose(sequence_error_flag));
  cover property ($fell(window_timeout_flag));
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import spi_wdt_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic cfg_rst_n = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  localparam int SIM_LSB = 4;
  localparam logic [63:0] GRAY_TAB = 64'h89BA_EFDC_4576_2310;
  logic act, tmo, seqe, gdo, cpo;
  logic [15:0] rep;
  logic [11:0] d;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  spi_wdt_if link_if();
  wdt_host wdt_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link_if));
  wdt_device #(.LSB_CYCLES(SIM_LSB)) wdt_device_inst (.hclk(hclk), .hresetn(hresetn),
    .cfg_rst_n(cfg_rst_n), .link(link_if), .supervisor_active_flag(act),
    .window_timeout_flag(tmo), .sequence_error_flag(seqe), .gate_drv_off(gdo),
    .charge_pump_off(cpo));
  spi_wdt_sva spi_wdt_sva_inst (.hclk(hclk), .hresetn(hresetn), .cfg_rst_n(cfg_rst_n),
    .sclk(link_if.sclk), .cs_n(link_if.cs_n), .miso(link_if.miso),
    .miso_oe(link_if.miso_oe), .miso_line(link_if.miso_line),
    .supervisor_active_flag(act), .window_timeout_flag(tmo),
    .sequence_error_flag(seqe), .gate_drv_off(gdo), .charge_pump_off(cpo));

  always #(CLK_PERIOD_NS / 2) hclk = ~hclk;

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors = errors + 1;
      $display("Error run length expected below limit seen %0d", cyc);
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("Error %s expected %0h seen %0h", w, e, g);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // One link frame; returns the reply to the previous frame
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    logic [31:0] s;
    s = 32'h1;
    while (s[0] !== 1'b0)
      ahb(1'b0, HOST_STATUS, 32'h0, s);
    ahb(1'b1, HOST_TX, {16'h0, w}, s);
    s = 32'h0;
    while (s[1] !== 1'b1)
      ahb(1'b0, HOST_STATUS, 32'h0, s);
    ahb(1'b0, HOST_RX, 32'h0, s);
    r = s[15:0];
    // Let the device act on the frame before anything is looked at
    repeat (2) @(posedge hclk);
  endtask

  task automatic dev_wr(input logic [2:0] a, input logic [11:0] v);
    xfer({1'b1, a, v}, rep);
  endtask

  task automatic dev_rd(input logic [2:0] a, output logic [11:0] v);
    xfer({1'b0, a, 12'h0}, rep);
    xfer({1'b0, a, 12'h0}, rep);
    v = rep[11:0];
  endtask

  task automatic refresh(input logic [3:0] c);
    xfer({1'b1, ADDR_REFRESH, 8'h0, c}, rep);
  endtask

  function automatic logic [11:0] cfgw(logic en, logic [1:0] win, logic [1:0] lim,
    logic [1:0] clr);
    return {5'h0, clr, lim, win, en};
  endfunction

  task automatic t_reset();
    chk("active flag", 1'b0, act);
    dev_rd(ADDR_STATUS, d);
    chk("status", 12'h0, d);
    dev_rd(ADDR_WCOUNT, d);
    chk("window count", 12'h0, d);
    chk("response", 1'b0, hresp);
    $display("test reset done");
  endtask

  task automatic t_timeout();
    int t0;
    dev_wr(ADDR_CFG, cfgw(1'b0, 2'h3, 2'h3, CLR_CMD_RST));
    dev_wr(ADDR_CFG, cfgw(1'b1, 2'h3, 2'h3, CLR_CMD_RST));
    t0 = cyc;
    chk("active flag", 1'b1, act);
    dev_rd(ADDR_WCOUNT, d);
    chk("count running", 1'b1, d > 0 && d < 13);
    dev_wr(ADDR_CFG, cfgw(1'b0, 2'h0, 2'h3, CLR_CMD_RST));
    chk("active kept", 1'b1, act);
    while (tmo !== 1'b1 && cyc - t0 < 3000)
      @(posedge hclk);
    chk("window length", 1'b1, cyc - t0 >= 1600 && cyc - t0 <= 1790);
    repeat (2) @(posedge hclk);
    chk("safe state", 2'h3, {gdo, cpo});
    repeat (200) @(posedge hclk);
    chk("timeout held", 1'b1, tmo);
    $display("test timeout done");
  endtask

  task automatic t_clear();
    for (int i = 0; i < 4; i++)
    begin
      if (i != 2)
      begin
        dev_wr(ADDR_CFG, cfgw(1'b1, 2'h3, 2'h3, 2'(i)));
        chk("no clear", 1'b1, tmo);
      end
    end
    dev_wr(ADDR_CFG, cfgw(1'b1, 2'h3, 2'h3, CLR_CMD_RESET));
    chk("cleared", 1'b0, tmo);
    chk("enable kept", 1'b1, act);
    chk("safe state off", 1'b0, gdo);
    $display("test clear done");
  endtask

  task automatic t_gray();
    logic [3:0] p;
    for (int k = 0; k <= 16; k++)
    begin
      refresh(4'(k));
      p = 4'(k - 1);
      if (k > 0)
        chk("gray reply", GRAY_TAB[p * 4 +: 4], rep[3:0]);
    end
    dev_rd(ADDR_STATUS, d);
    chk("status", 12'h1, d);
    $display("test gray done");
  endtask

  task automatic t_seq();
    int lim;
    refresh(4'h9);
    dev_rd(ADDR_STATUS, d);
    chk("error count", 2'h1, d[4:3]);
    dev_wr(ADDR_CFG, cfgw(1'b1, 2'h3, 2'h3, CLR_CMD_RESET));
    dev_rd(ADDR_STATUS, d);
    chk("error count", 2'h1, d[4:3]);
    refresh(4'h1);
    dev_rd(ADDR_STATUS, d);
    chk("error count", 2'h0, d[4:3]);
    for (int i = 0; i < 4; i++)
    begin
      lim = (i < 2) ? 1 : i;
      dev_wr(ADDR_CFG, cfgw(1'b1, 2'h3, 2'(i), CLR_CMD_RST));
      for (int j = 1; j <= lim; j++)
      begin
        refresh(4'h9);
        chk("sequence flag", j == lim, seqe);
      end
      dev_wr(ADDR_CFG, cfgw(1'b1, 2'h3, 2'(i), CLR_CMD_RESET));
      chk("sequence cleared", 1'b0, seqe);
    end
    $display("test sequence done");
  endtask

  task automatic t_cfgrst();
    int t0;
    @(posedge hclk);
    cfg_rst_n <= 1'b0;
    @(posedge hclk);
    cfg_rst_n <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("active flag", 1'b0, act);
    dev_rd(ADDR_WCOUNT, d);
    chk("window count", 12'h0, d);
    dev_wr(ADDR_CFG, cfgw(1'b0, 2'h0, 2'h3, CLR_CMD_RST));
    dev_wr(ADDR_CFG, cfgw(1'b1, 2'h0, 2'h3, CLR_CMD_RST));
    t0 = cyc;
    while (tmo !== 1'b1 && cyc - t0 < 3000)
      @(posedge hclk);
    chk("short window", 1'b1, (cyc - t0) * 10 >= WIN_STEPS_INT * SIM_LSB * 9
      && (cyc - t0) * 10 <= WIN_STEPS_INT * SIM_LSB * 11);
    $display("test config reset done");
  endtask

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_timeout();
    t_clear();
    t_gray();
    t_seq();
    t_cfgrst();
    summarize();
  end
endmodule
